// ==== core/ect_pkg.sv ====
/*
  constants for the eight-bit compare timer: register offsets, mode register
  field positions, reset values, clock-select and mode codes.
  assumes a byte-wide internal register port with 16-bit addresses.
*/
package ect_pkg;
  localparam int unsigned ect_addr_w = 16;
  localparam int unsigned ect_data_w = 8;

  // register offsets
  localparam logic [15:0] ect_mode_off = 16'hff69;
  localparam logic [15:0] ect_prim_off = 16'hff6a;
  localparam logic [15:0] ect_sec_off = 16'hff6b;
  localparam logic [15:0] ect_cnt_off = 16'hff6e;

  // reset values
  localparam logic [7:0] ect_mode_rst = 8'h00;
  localparam logic [7:0] ect_prim_rst = 8'h00;
  localparam logic [7:0] ect_sec_rst = 8'h00;

  // mode register fields
  localparam int unsigned ect_run_bit = 7;
  localparam int unsigned ect_cks_hi = 6;
  localparam int unsigned ect_cks_lo = 4;
  localparam int unsigned ect_md_hi = 3;
  localparam int unsigned ect_md_lo = 2;
  localparam int unsigned ect_lev_bit = 1;
  localparam int unsigned ect_oen_bit = 0;

  // clock-select codes
  localparam logic [2:0] ect_cks_div1 = 3'h0;
  localparam logic [2:0] ect_cks_div2 = 3'h1;
  localparam logic [2:0] ect_cks_div4 = 3'h2;
  localparam logic [2:0] ect_cks_div64 = 3'h3;
  localparam logic [2:0] ect_cks_div1024 = 3'h4;
  localparam logic [2:0] ect_cks_evc0 = 3'h5;

  // prescaler tap widths (log2 of each division)
  localparam int unsigned ect_pre_w = 10;
  localparam int unsigned ect_log_div2 = 1;
  localparam int unsigned ect_log_div4 = 2;
  localparam int unsigned ect_log_div64 = 6;
  localparam int unsigned ect_log_div1024 = 10;

  // operating modes
  localparam logic [1:0] ect_md_interval = 2'h0;
  localparam logic [1:0] ect_md_carrier = 2'h1;
  localparam logic [1:0] ect_md_pwm = 2'h2;

  typedef enum logic [1:0] {
    ect_mode_interval,
    ect_mode_carrier,
    ect_mode_pwm,
    ect_mode_bad
  } ect_mode_t;
endpackage : ect_pkg

// ==== core/ect_clk_sel.sv ====
/*
  count-clock enable generator: prescaler taps of the core clock and the
  rising edge of event counter zero's output, picked by the select field.
  assumes the event counter output is synchronous to core_clk.
*/
`timescale 1ns/1ns
module ect_clk_sel (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] clk_sel,
  input wire logic event_counter_zero,
  output logic count_tick
);
  import ect_pkg::*;

  logic [ect_pre_w-1:0] prescale;
  logic evc_prev;
  logic next_tick;

  // free-running prescaler; taps are taken where the low bits are all ones
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= '0;
      evc_prev <= 1'b0;
    end else begin
      prescale <= prescale + 1'b1;
      evc_prev <= event_counter_zero;
    end
  end

  // select the tap; prohibited codes give no tick so the counter just holds
  always_comb begin
    unique case (clk_sel)
      ect_cks_div1: next_tick = 1'b1;
      ect_cks_div2: next_tick = &prescale[ect_log_div2-1:0];
      ect_cks_div4: next_tick = &prescale[ect_log_div4-1:0];
      ect_cks_div64: next_tick = &prescale[ect_log_div64-1:0];
      ect_cks_div1024: next_tick = &prescale[ect_log_div1024-1:0];
      ect_cks_evc0: next_tick = event_counter_zero & ~evc_prev;
      default: next_tick = 1'b0;
    endcase
  end

  // registered so the timer sees a clean one-cycle enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_tick <= 1'b0;
    end else begin
      count_tick <= next_tick;
    end
  end
endmodule : ect_clk_sel

// ==== core/ect_timer.sv ====
/*
  one channel of the eight-bit compare timer: mode register, primary and
  secondary compare registers, counter, output flip-flop and match request.
  assumes single-cycle byte writes and reads on an internal register port;
  channel_one selects the instance that has carrier mode and an output pin.
*/
// Notes on behaviour
// R1 - primary compare matched always: raise request and toggle output (code: neither in a prohibited mode, no toggle if secondary matches same tick)
// R2 - software changes primary compare only while stopped
// R3 - reset clears both compare registers to zero
// R4 - secondary compare used only in pwm and carrier modes
// R5 - pwm: secondary match toggles output, raises no request
// R6 - carrier: secondary match raises request and clears counter
// R7 - secondary write while running is buffered until old value matches
// R8 - write colliding with secondary match leaves active value unchanged
// R9 - software rewrites secondary compare at every restart in pwm/carrier
// R10 - run bit clear stops and zeroes counter; set counts each tick
// R11 - select field picks divide 1,2,4,64,1024 or event counter zero
// R12 - mode field: 00 interval, 10 pwm, others prohibited on channel zero
// R13 - level bit sets default output level; enable bit gates the pin
// R14 - software leaves other mode bits alone while running
// R15 - event counter zero started before its toggling is enabled
// R16 - event counter zero in pwm: start first, 50% duty
// R17 - only channel one has carrier mode and an external pin
// R18 - interval: primary match requests and clears, period compare plus one
// R19 - interval: secondary register ignored entirely
// R20 - pwm: primary match clears and toggles, secondary match toggles
// R21 - output disabled: pin holds default level, toggles hidden
`timescale 1ns/1ns
module ect_timer #(
  parameter bit channel_one = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ect_pkg::ect_addr_w-1:0] reg_addr,
  input wire logic [ect_pkg::ect_data_w-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ect_pkg::ect_data_w-1:0] reg_rdata,
  input wire logic event_counter_zero,
  output logic compare_match_irq,
  output logic timer_output,
  output logic channel_one_output_pin,
  output logic channel_one_output_oe
);
  import ect_pkg::*;

  logic [7:0] timer_mode_control;
  logic [7:0] primary_compare;
  logic [7:0] secondary_compare;
  logic [7:0] sec_active;
  logic sec_pending;
  logic [7:0] counter;
  logic toggle_ff;
  logic count_tick;
  ect_mode_t mode;
  logic run_enable;
  logic level_bit;
  logic oen_bit;
  logic match0;
  logic match1;
  logic sec_used;
  logic wr_mode;
  logic wr_prim;
  logic wr_sec;
  logic clear_cnt;
  logic toggle_now;
  logic req_now;

  assign run_enable = timer_mode_control[ect_run_bit];
  assign level_bit = timer_mode_control[ect_lev_bit];
  assign oen_bit = timer_mode_control[ect_oen_bit];
  assign wr_mode = reg_wr && (reg_addr == ect_mode_off);
  assign wr_prim = reg_wr && (reg_addr == ect_prim_off);
  assign wr_sec = reg_wr && (reg_addr == ect_sec_off);

  // decode mode; carrier exists on channel one only, so it is illegal on zero
  always_comb begin
    unique case (timer_mode_control[ect_md_hi:ect_md_lo])
      ect_md_interval: mode = ect_mode_interval; // R12
      ect_md_pwm: mode = ect_mode_pwm; // R12
      ect_md_carrier: mode = channel_one ? ect_mode_carrier : ect_mode_bad; // R17
      default: mode = ect_mode_bad;
    endcase
  end

  ect_clk_sel u_clk_sel (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_sel(timer_mode_control[ect_cks_hi:ect_cks_lo]),
    .event_counter_zero(event_counter_zero),
    .count_tick(count_tick)
  );

  // compare events are judged on a count tick while running
  assign sec_used = (mode == ect_mode_pwm) || (mode == ect_mode_carrier); // R4 R19
  assign match0 = run_enable && count_tick && (counter == primary_compare); // R1
  assign match1 = run_enable && count_tick && sec_used && (counter == sec_active);

  // per-mode effects of a match; a prohibited mode only counts and wraps
  always_comb begin
    clear_cnt = 1'b0;
    toggle_now = 1'b0;
    req_now = 1'b0;
    unique case (mode)
      ect_mode_interval: begin
        clear_cnt = match0; // R18
        toggle_now = match0; // R1
        req_now = match0; // R1 R18
      end
      ect_mode_pwm: begin
        clear_cnt = match0; // R20
        toggle_now = match0 ^ match1; // R5 R20
        req_now = match0; // R5
      end
      ect_mode_carrier: begin
        clear_cnt = match1; // R6
        toggle_now = match0 ^ match1;
        req_now = match0 | match1; // R1 R6
      end
      ect_mode_bad: begin
        clear_cnt = 1'b0;
      end
    endcase
  end

  // mode register; software is trusted not to change it while running
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_mode_control <= ect_mode_rst;
    end else if (wr_mode) begin
      timer_mode_control <= reg_wdata; // R14
    end
  end

  // primary compare; writes land at once, software only changes it stopped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_compare <= ect_prim_rst; // R3
    end else if (wr_prim) begin
      primary_compare <= reg_wdata; // R2
    end
  end

  // secondary compare: written value is buffered, active copy loads when
  // stopped at once, when running only on a match of the old active value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      secondary_compare <= ect_sec_rst; // R3
      sec_active <= ect_sec_rst; // R3
      sec_pending <= 1'b0;
    end else begin
      if (wr_sec) begin
        secondary_compare <= reg_wdata;
      end
      if (wr_sec && !run_enable) begin
        sec_active <= reg_wdata; // R9
        sec_pending <= 1'b0;
      end else if (wr_sec) begin
        sec_pending <= 1'b1; // R7 R8
      end else if (match1 && sec_pending) begin
        sec_active <= secondary_compare; // R7
        sec_pending <= 1'b0;
      end
    end
  end

  // counter: cleared while stopped, counts on each selected tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter <= 8'h00;
    end else if (!run_enable) begin
      counter <= 8'h00; // R10
    end else if (clear_cnt) begin
      counter <= 8'h00; // R18 R6
    end else if (count_tick) begin
      counter <= counter + 8'h01; // R10 R11
    end
  end

  // output flip-flop restarts from the default level whenever stopped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_ff <= 1'b0;
    end else if (!run_enable) begin
      toggle_ff <= level_bit; // R13
    end else if (toggle_now) begin
      toggle_ff <= ~toggle_ff; // R1
    end
  end

  // pins and request; disabled output parks at the default level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_match_irq <= 1'b0;
      timer_output <= 1'b0;
      channel_one_output_pin <= 1'b0;
      channel_one_output_oe <= 1'b0;
    end else begin
      compare_match_irq <= req_now; // R1
      timer_output <= oen_bit ? toggle_ff : level_bit; // R13 R21
      channel_one_output_pin <= channel_one && (oen_bit ? toggle_ff : level_bit); // R17 R21
      channel_one_output_oe <= channel_one && oen_bit; // R13 R17
    end
  end

  // read port; unmapped addresses read as zero, secondary reads the buffer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ect_mode_off: reg_rdata <= timer_mode_control;
        ect_prim_off: reg_rdata <= primary_compare;
        ect_sec_off: reg_rdata <= secondary_compare;
        ect_cnt_off: reg_rdata <= counter;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : ect_timer

// ==== verif/ect_timer_assertions.sv ====
/* port checker for ect_timer, with shadows of the mode and primary registers.
   assumes writes are taken on the edge that sees reg_wr high. */
`timescale 1ns/1ns
module ect_chk import ect_pkg::*; #(
  parameter bit channel_one = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic event_counter_zero,
  input wire logic compare_match_irq,
  input wire logic timer_output,
  input wire logic channel_one_output_pin,
  input wire logic channel_one_output_oe
);
  logic [7:0] mode_q;
  logic [7:0] prim_q;
  logic [9:0] gap;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // shadows follow the write port
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 8'h00;
      prim_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ect_mode_off) mode_q <= reg_wdata;
      if (reg_addr == ect_prim_off) prim_q <= reg_wdata;
    end
  end
  // cycles since last request; any write voids it so stale gaps are skipped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) gap <= 10'h3ff;
    else if (reg_wr) gap <= 10'h3ff;
    else if (compare_match_irq) gap <= 10'h001;
    else if (gap != 10'h3ff) gap <= gap + 10'h001;
  end
  period_exact_a: assert property (compare_match_irq && gap != 10'h3ff && mode_q[7]
    && mode_q[6:4] == ect_cks_div1 && !mode_q[2] |-> gap == {2'b00, prim_q} + 10'h001)
    else $error("request spacing differs from primary plus one");
  stop_quiet_a: assert property (!mode_q[7] && !$past(mode_q[7]) |-> !compare_match_irq)
    else $error("request while stopped");
  out_default_a: assert property (!mode_q[0] && $past(mode_q) == mode_q
    |-> timer_output == mode_q[1]) else $error("disabled output not at default level");
  // the pin is registered from the output flip-flop, so it moves one cycle after the request
  toggle_match_a: assert property (mode_q[7] && $past(mode_q) == mode_q
    && $past(mode_q, 2) == mode_q && mode_q[0] && mode_q[3:2] == ect_md_interval
    |-> $changed(timer_output) == $past(compare_match_irq))
    else $error("output toggle not tied to request");
  prim_read_a: assert property (reg_rd && reg_addr == ect_prim_off |=> reg_rdata == $past(prim_q))
    else $error("primary read mismatch");
  mode_read_a: assert property (reg_rd && reg_addr == ect_mode_off |=> reg_rdata == $past(mode_q))
    else $error("mode read mismatch");
  pin_zero_a: assert property (!channel_one |-> !channel_one_output_pin && !channel_one_output_oe)
    else $error("channel zero drives the pin");
  bad_mode_a: assert property (mode_q[3:2] == 2'h3 && $past(mode_q) == mode_q
    |-> !compare_match_irq) else $error("request in prohibited mode");
  cnt_stop_a: assert property (reg_rd && reg_addr == ect_cnt_off && !mode_q[7]
    && !$past(mode_q[7]) |=> reg_rdata == 8'h00) else $error("counter not cleared");
  period_c: cover property (compare_match_irq && gap != 10'h3ff);
  pwm_c: cover property (compare_match_irq && mode_q[3:2] == ect_md_pwm);
  bad_c: cover property (mode_q[7] && mode_q[3:2] == 2'h3);
endmodule : ect_chk

bind ect_timer ect_chk #(.channel_one(channel_one)) chk_i (.core_clk(core_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .event_counter_zero(event_counter_zero),
  .compare_match_irq(compare_match_irq), .timer_output(timer_output),
  .channel_one_output_pin(channel_one_output_pin), .channel_one_output_oe(channel_one_output_oe));

// ==== verif/test_eight_bit_compare_timer.sv ====
/* self-checking bench for a channel-zero ect_timer.
   assumes the checker is bound in from its own file. */
`timescale 1ns/1ns
module test_eight_bit_compare_timer;
  import ect_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic event_counter_zero = 1'b0;
  logic [7:0] reg_rdata;
  logic compare_match_irq;
  logic timer_output;
  logic pin;
  logic oe;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'hb7425056;
  int gap;
  int tog;
  logic [31:0] r;
  logic [7:0] p;
  logic [7:0] s;
  ect_timer dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_counter_zero(event_counter_zero), .compare_match_irq(compare_match_irq),
    .timer_output(timer_output), .channel_one_output_pin(pin), .channel_one_output_oe(oe));
  // clock, and an event source rising every six cycles
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // source runs from time zero at even duty, before the timer ever selects it
  always begin
    repeat (3) @(posedge core_clk);
    event_counter_zero <= ~event_counter_zero;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle strobes, released on the edge that takes them
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(what, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  // request period in core cycles for a primary value and clock source
  function automatic logic [15:0] exp_period(input logic [7:0] pv, input logic [2:0] c);
    logic [15:0] n;
    n = {8'h00, pv} + 16'h0001;
    case (c)
      ect_cks_div1: return n;
      ect_cks_div2: return n << 1;
      ect_cks_div4: return n << 2;
      ect_cks_div64: return n << 6;
      ect_cks_div1024: return n << 10;
      default: return n * 16'h0006;
    endcase
  endfunction : exp_period
  // spacing from one request to the next, and output changes between them
  task automatic meas(output int g, output int t);
    int n;
    logic last;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (compare_match_irq !== 1'b1 && n < 20000);
    g = 0;
    t = 0;
    last = timer_output;
    do begin
      @(posedge core_clk);
      #1;
      g++;
      if (timer_output !== last) t++;
      last = timer_output;
    end while (compare_match_irq !== 1'b1 && g < 20000);
  endtask : meas
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(ect_mode_off, 8'h00, "mode");
    rd(ect_prim_off, 8'h00, "primary");
    rd(ect_sec_off, 8'h00, "secondary");
    rd(16'hff00, 8'h00, "unmapped");
    // each clock source, then the primary extremes; secondary set but unused
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      p = (i == 6) ? 8'h01 : (i == 7) ? 8'hff : 8'h01 + {5'h00, r[2:0]};
      wr(ect_prim_off, p);
      wr(ect_sec_off, r[15:8]);
      wr(ect_mode_off, {1'b1, (i < 6) ? 3'(i) : 3'h0, ect_md_interval, 2'b01});
      meas(gap, tog);
      chk("period", exp_period(p, (i < 6) ? 3'(i) : 3'h0), gap[15:0]);
      chk("toggles", 16'h0001, tog[15:0]);
      wr(ect_mode_off, 8'h01);
      rd(ect_cnt_off, 8'h00, "counter");
      chk("idle level", 16'h0000, {15'h0000, timer_output});
    end
    // pwm: period from primary, second toggle from secondary
    r = $random(seed);
    p = 8'h10 + {4'h0, r[3:0]};
    wr(ect_prim_off, p);
    wr(ect_sec_off, 8'h01 + {5'h00, r[6:4]});
    wr(ect_mode_off, {1'b1, ect_cks_div1, ect_md_pwm, 2'b11});
    meas(gap, tog);
    chk("pwm period", exp_period(p, ect_cks_div1), gap[15:0]);
    chk("pwm toggles", 16'h0002, tog[15:0]);
    wr(ect_sec_off, 8'h0a);
    rd(ect_sec_off, 8'h0a, "buffered");
    meas(gap, tog);
    meas(gap, tog);
    chk("pwm toggles", 16'h0002, tog[15:0]);
    // output disabled: output holds the default level, pin stays low
    wr(ect_mode_off, 8'h00);
    wr(ect_mode_off, 8'h82);
    rd(ect_mode_off, 8'h82, "mode");
    meas(gap, tog);
    chk("held toggles", 16'h0000, tog[15:0]);
    chk("held level", 16'h0001, {15'h0000, timer_output});
    chk("pin", 16'h0000, {14'h0000, pin, oe});
    // prohibited mode raises nothing
    wr(ect_mode_off, 8'h00);
    wr(ect_mode_off, 8'h8d);
    tog = 0;
    repeat (300) begin
      @(posedge core_clk);
      #1;
      if (compare_match_irq !== 1'b0) tog++;
    end
    chk("bad mode requests", 16'h0000, tog[15:0]);
    complete_run();
  end
endmodule : test_eight_bit_compare_timer
